// File: rtl/fpmux_pixel_out.sv
// Flat panel low data bits, shift clocks, latch and frame pulses
//
// Summary of operation
// - Mono STN: pixel bits 2..0 straight out
// - TFT: green bits 2..0 on lines
// - STN first order and 16-bit: bits same-numbered
// - STN second order: bits 5,6,7 to lines 2,1,0
// - STN second order: bit 7 on line 0
// - Dual 16-bit STN: lower half bits 2..0
// - External RAMDAC: pixel index bits 2..0
// - Dual panel: lines carry lower panel bits
// - Extender mode: release lines, sample as inputs
// - Driven data lines are active high
// - Mono and TFT: toggle main shift clock
// - STN second order: low-half shift clock
// - STN first order: high-half shift clock
// - Aux control bit 7 enters extender mode
// - Left-most pixel on bit 3 or 7
// - Plasma: 4-bit reserved, 8-bit second pixel
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module fpmux_pixel_out #(
   parameter int DATA_W = 16,
   parameter int CNT_W = 12
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic pixel_clk_in,
   input wire logic [DATA_W-1:0] src_data,
   output logic src_ready,
   output logic [2:0] panel_data_out,
   output logic [2:0] panel_data_oe,
   input wire logic [2:0] panel_data_in,
   output logic column_shift_clock,
   output logic column_shift_clock_low_half,
   output logic column_shift_clock_high_half,
   output logic row_latch_pulse,
   output logic frame_start_pulse,
   output logic [2:0] extender_pixel,
   output logic video_extender_mode
);

   typedef struct packed {
      fpmux_pkg::fpmux_mode_type mode;
      logic enable;
      logic extender;
      logic [CNT_W-1:0] line_words;
      logic [CNT_W-1:0] frame_lines;
      logic [CNT_W-1:0] word_count;
      logic [CNT_W-1:0] line_count;
      fpmux_pkg::fpmux_state_type state;
      logic sclk;
      logic [2:0] data_out;
      logic [2:0] data_oe;
      logic sclk_main;
      logic sclk_low;
      logic sclk_high;
      logic latch;
      logic frame;
      logic ready;
      logic [2:0] ext_pix;
      logic [31:0] rdata;
   } fpmux_state_reg_type;

   fpmux_state_reg_type st_reg;
   fpmux_state_reg_type st_next;

   logic pclk_rise;
   logic [2:0] ext_level;

   // Pixel clock arrives from outside; only its edges matter here
   fpmux_sync_edge #(
      .WIDTH(1)
   ) u_pclk_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in(pixel_clk_in),
      .level(),
      .rise(pclk_rise)
   );

   fpmux_sync_edge #(
      .WIDTH(3)
   ) u_ext_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in(panel_data_in),
      .level(ext_level),
      .rise()
   );

   // Select the three line bits for the active panel type
   function automatic logic [2:0] map_bits(input fpmux_pkg::fpmux_mode_type mode,
                                           input logic [DATA_W-1:0] word);
      logic [2:0] bits;
      bits = 3'h0;
      case (mode)
         // left-most pixel kept at top bit
         fpmux_pkg::FPMUX_MONO4, fpmux_pkg::FPMUX_MONO8: begin
            bits = word[2:0];
         end
         fpmux_pkg::FPMUX_MONO_DUAL: begin
            bits = word[2:0];
         end
         fpmux_pkg::FPMUX_TFT: begin
            bits = word[fpmux_pkg::FPMUX_TFT_GREEN_LSB +: 3];
         end
         fpmux_pkg::FPMUX_STN_A8, fpmux_pkg::FPMUX_STN16: begin
            bits = word[2:0];
         end
         fpmux_pkg::FPMUX_STN_B8: begin
            bits[2] = word[fpmux_pkg::FPMUX_STN_B_LINE2_SRC];
            bits[1] = word[fpmux_pkg::FPMUX_STN_B_LINE1_SRC];
            bits[0] = word[fpmux_pkg::FPMUX_STN_B_LINE0_SRC];
         end
         fpmux_pkg::FPMUX_STN_DUAL16: begin
            bits = word[2:0];
         end
         fpmux_pkg::FPMUX_RAMDAC: begin
            bits = word[2:0];
         end
         fpmux_pkg::FPMUX_PLASMA8: begin
            bits = word[2:0];
         end
         fpmux_pkg::FPMUX_PLASMA4: begin
            bits = 3'h0;
         end
         default: begin
            bits = 3'h0;
         end
      endcase
      return bits;
   endfunction

   // Which shift clock pin carries the toggling clock
   function automatic fpmux_pkg::fpmux_route_type route_of(input fpmux_pkg::fpmux_mode_type mode);
      fpmux_pkg::fpmux_route_type route;
      route = fpmux_pkg::FPMUX_ROUTE_NONE;
      case (mode)
         fpmux_pkg::FPMUX_STN_B8: begin
            route = fpmux_pkg::FPMUX_ROUTE_LOW;
         end
         fpmux_pkg::FPMUX_STN_A8: begin
            route = fpmux_pkg::FPMUX_ROUTE_HIGH;
         end
         // main clock for mono, TFT, 16-bit and dual 16-bit STN, RAMDAC and plasma
         fpmux_pkg::FPMUX_MONO4, fpmux_pkg::FPMUX_MONO8, fpmux_pkg::FPMUX_MONO_DUAL,
         fpmux_pkg::FPMUX_TFT, fpmux_pkg::FPMUX_STN16, fpmux_pkg::FPMUX_STN_DUAL16,
         fpmux_pkg::FPMUX_RAMDAC, fpmux_pkg::FPMUX_PLASMA4, fpmux_pkg::FPMUX_PLASMA8: begin
            route = fpmux_pkg::FPMUX_ROUTE_MAIN;
         end
         default: begin
            route = fpmux_pkg::FPMUX_ROUTE_NONE;
         end
      endcase
      return route;
   endfunction

   always_comb begin
      logic run;
      logic last_word;
      logic last_line;
      fpmux_pkg::fpmux_route_type route;
      run = 1'b0;
      last_word = 1'b0;
      last_line = 1'b0;
      route = fpmux_pkg::FPMUX_ROUTE_NONE;
      st_next = st_reg;
      st_next.ready = 1'b0;
      st_next.rdata = 32'h0000_0000;

      // Register writes
      if (reg_write) begin
         case (reg_addr)
            fpmux_pkg::FPMUX_CTRL_OFFSET: begin
               st_next.mode = fpmux_pkg::fpmux_mode_type'(
                  reg_wdata[fpmux_pkg::FPMUX_CTRL_MODE_LSB +: fpmux_pkg::FPMUX_CTRL_MODE_W]);
               st_next.enable = reg_wdata[fpmux_pkg::FPMUX_CTRL_ENABLE_BIT];
            end
            fpmux_pkg::FPMUX_AUX_OFFSET: begin
               st_next.extender = reg_wdata[fpmux_pkg::FPMUX_AUX_EXTENDER_BIT];
            end
            fpmux_pkg::FPMUX_LINE_OFFSET: begin
               st_next.line_words = reg_wdata[CNT_W-1:0];
            end
            fpmux_pkg::FPMUX_FRAME_OFFSET: begin
               st_next.frame_lines = reg_wdata[CNT_W-1:0];
            end
            default: begin
               st_next.enable = st_reg.enable;
            end
         endcase
      end

      // Register reads, data valid the following cycle only
      if (reg_read) begin
         case (reg_addr)
            fpmux_pkg::FPMUX_CTRL_OFFSET: begin
               st_next.rdata[fpmux_pkg::FPMUX_CTRL_MODE_LSB +: fpmux_pkg::FPMUX_CTRL_MODE_W] = st_reg.mode;
               st_next.rdata[fpmux_pkg::FPMUX_CTRL_ENABLE_BIT] = st_reg.enable;
            end
            fpmux_pkg::FPMUX_AUX_OFFSET: begin
               st_next.rdata[fpmux_pkg::FPMUX_AUX_EXTENDER_BIT] = st_reg.extender;
            end
            fpmux_pkg::FPMUX_LINE_OFFSET: begin
               st_next.rdata[CNT_W-1:0] = st_reg.line_words;
            end
            fpmux_pkg::FPMUX_FRAME_OFFSET: begin
               st_next.rdata[CNT_W-1:0] = st_reg.frame_lines;
            end
            fpmux_pkg::FPMUX_STATUS_OFFSET: begin
               st_next.rdata[CNT_W-1:0] = st_reg.line_count;
               st_next.rdata[fpmux_pkg::FPMUX_STATUS_EXT_LSB +: 3] = st_reg.ext_pix;
               st_next.rdata[fpmux_pkg::FPMUX_STATUS_BUSY_BIT] = (st_reg.state != fpmux_pkg::FPMUX_IDLE);
               st_next.rdata[fpmux_pkg::FPMUX_STATUS_FRAME_BIT] = st_reg.frame;
            end
            default: begin
               st_next.rdata = 32'h0000_0000;
            end
         endcase
      end

      // extender inputs sampled for the internal RAMDAC
      st_next.ext_pix = st_reg.extender ? ext_level : 3'h0;
      // driven lines carry data active high
      st_next.data_oe = st_reg.extender ? 3'h0 : 3'h7;

      run = st_reg.enable && !st_reg.extender;
      last_word = ({1'b0, st_reg.word_count} + (CNT_W+1)'(1)) >= {1'b0, st_reg.line_words};
      last_line = ({1'b0, st_reg.line_count} + (CNT_W+1)'(1)) >= {1'b0, st_reg.frame_lines};

      if (!run) begin
         // Stopping mid-line abandons it; next start begins a fresh frame
         st_next.state = fpmux_pkg::FPMUX_IDLE;
         st_next.sclk = 1'b0;
         st_next.latch = 1'b0;
         st_next.frame = 1'b0;
         st_next.word_count = '0;
         st_next.line_count = '0;
         if (st_reg.extender) begin
            st_next.data_out = 3'h0;
         end
      end else if (pclk_rise) begin
         case (st_reg.state)
            fpmux_pkg::FPMUX_IDLE: begin
               st_next.state = fpmux_pkg::FPMUX_LOAD;
            end
            // new data with falling shift clock
            fpmux_pkg::FPMUX_LOAD: begin
               st_next.sclk = 1'b0;
               st_next.latch = 1'b0;
               st_next.data_out = map_bits(st_reg.mode, src_data);
               st_next.ready = 1'b1;
               // frame pulse over the first line
               st_next.frame = (st_reg.line_count == '0);
               st_next.state = fpmux_pkg::FPMUX_RISE;
            end
            // rising edge clocks the word in
            fpmux_pkg::FPMUX_RISE: begin
               st_next.sclk = 1'b1;
               if (last_word) begin
                  st_next.word_count = '0;
                  st_next.state = fpmux_pkg::FPMUX_LATCH;
               end else begin
                  st_next.word_count = st_reg.word_count + CNT_W'(1);
                  st_next.state = fpmux_pkg::FPMUX_LOAD;
               end
            end
            fpmux_pkg::FPMUX_LATCH: begin
               st_next.sclk = 1'b0;
               st_next.latch = 1'b1;
               st_next.line_count = last_line ? '0 : st_reg.line_count + CNT_W'(1);
               st_next.state = fpmux_pkg::FPMUX_LOAD;
            end
            default: begin
               st_next.state = fpmux_pkg::FPMUX_IDLE;
            end
         endcase
      end

      // only the routed shift clock toggles
      route = route_of(st_reg.mode);
      st_next.sclk_main = st_next.sclk && (route == fpmux_pkg::FPMUX_ROUTE_MAIN);
      st_next.sclk_low = st_next.sclk && (route == fpmux_pkg::FPMUX_ROUTE_LOW);
      st_next.sclk_high = st_next.sclk && (route == fpmux_pkg::FPMUX_ROUTE_HIGH);
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         st_reg <= '0;
         st_reg.mode <= fpmux_pkg::FPMUX_MONO4;
         st_reg.enable <= fpmux_pkg::FPMUX_ENABLE_RESET;
         st_reg.extender <= fpmux_pkg::FPMUX_EXTENDER_RESET;
         st_reg.line_words <= CNT_W'(fpmux_pkg::FPMUX_LINE_WORDS_RESET);
         st_reg.frame_lines <= CNT_W'(fpmux_pkg::FPMUX_FRAME_LINES_RESET);
         st_reg.state <= fpmux_pkg::FPMUX_IDLE;
         st_reg.data_oe <= 3'h7;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign src_ready = st_reg.ready;
   assign panel_data_out = st_reg.data_out;
   assign panel_data_oe = st_reg.data_oe;
   assign column_shift_clock = st_reg.sclk_main;
   assign column_shift_clock_low_half = st_reg.sclk_low;
   assign column_shift_clock_high_half = st_reg.sclk_high;
   assign row_latch_pulse = st_reg.latch;
   assign frame_start_pulse = st_reg.frame;
   assign extender_pixel = st_reg.ext_pix;
   assign video_extender_mode = st_reg.extender;

endmodule
`default_nettype wire

// File: rtl/fpmux_pkg.sv
// Shared constants and types for the flat panel pixel output mux
package fpmux_pkg;

   // Register byte offsets
   localparam logic [7:0] FPMUX_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] FPMUX_AUX_OFFSET = 8'h04;
   localparam logic [7:0] FPMUX_LINE_OFFSET = 8'h08;
   localparam logic [7:0] FPMUX_FRAME_OFFSET = 8'h0C;
   localparam logic [7:0] FPMUX_STATUS_OFFSET = 8'h10;

   // Field positions
   localparam int FPMUX_CTRL_MODE_LSB = 0;
   localparam int FPMUX_CTRL_MODE_W = 4;
   localparam int FPMUX_CTRL_ENABLE_BIT = 4;
   localparam int FPMUX_AUX_EXTENDER_BIT = 7;
   localparam int FPMUX_STATUS_EXT_LSB = 16;
   localparam int FPMUX_STATUS_BUSY_BIT = 19;
   localparam int FPMUX_STATUS_FRAME_BIT = 20;
   localparam int FPMUX_TFT_GREEN_LSB = 8;
   localparam int FPMUX_STN_B_LINE2_SRC = 5;
   localparam int FPMUX_STN_B_LINE1_SRC = 6;
   localparam int FPMUX_STN_B_LINE0_SRC = 7;

   // Values after reset
   localparam logic FPMUX_ENABLE_RESET = 1'h0;
   localparam logic FPMUX_EXTENDER_RESET = 1'h0;
   localparam logic [11:0] FPMUX_LINE_WORDS_RESET = 12'h050;
   localparam logic [11:0] FPMUX_FRAME_LINES_RESET = 12'h0F0;

   typedef enum logic [3:0] {
      FPMUX_MONO4 = 4'h0,
      FPMUX_MONO8 = 4'h1,
      FPMUX_MONO_DUAL = 4'h2,
      FPMUX_TFT = 4'h3,
      FPMUX_STN_A8 = 4'h4,
      FPMUX_STN_B8 = 4'h5,
      FPMUX_STN16 = 4'h6,
      FPMUX_STN_DUAL16 = 4'h7,
      FPMUX_RAMDAC = 4'h8,
      FPMUX_PLASMA4 = 4'h9,
      FPMUX_PLASMA8 = 4'hA
   } fpmux_mode_type;

   typedef enum logic [1:0] {
      FPMUX_IDLE = 2'h0,
      FPMUX_LOAD = 2'h1,
      FPMUX_RISE = 2'h2,
      FPMUX_LATCH = 2'h3
   } fpmux_state_type;

   typedef enum logic [1:0] {
      FPMUX_ROUTE_NONE = 2'h0,
      FPMUX_ROUTE_MAIN = 2'h1,
      FPMUX_ROUTE_LOW = 2'h2,
      FPMUX_ROUTE_HIGH = 2'h3
   } fpmux_route_type;

endpackage

// File: rtl/fpmux_sync_edge.sv
// Two-stage synchroniser with rising edge detection, per bit
`timescale 1ns/100ps
`default_nettype none
module fpmux_sync_edge #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
      logic [WIDTH-1:0] level;
      logic [WIDTH-1:0] rise;
   } fpmux_sync_type;

   fpmux_sync_type st_reg;
   fpmux_sync_type st_next;

   // Stage1 feeds only stage2; edge logic looks at stage2 and later
   always_comb begin
      st_next = st_reg;
      st_next.stage1 = async_in;
      st_next.stage2 = st_reg.stage1;
      st_next.level = st_reg.stage2;
      st_next.rise = st_reg.stage2 & ~st_reg.level;
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level = st_reg.level;
   assign rise = st_reg.rise;

endmodule
`default_nettype wire

// File: test/fpmux_props.sv
// Port-level assertions for the pixel output mux
`timescale 1ns/100ps
`default_nettype none
module fpmux_props (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic [2:0] panel_data_out,
   input wire logic [2:0] panel_data_oe,
   input wire logic column_shift_clock,
   input wire logic column_shift_clock_low_half,
   input wire logic column_shift_clock_high_half,
   input wire logic row_latch_pulse,
   input wire logic frame_start_pulse,
   input wire logic [2:0] extender_pixel,
   input wire logic video_extender_mode
);
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   logic [2:0] sclks;
   logic any_sclk;
   assign sclks = {column_shift_clock, column_shift_clock_low_half, column_shift_clock_high_half};
   assign any_sclk = |sclks;
   a_oe_released: assert property (video_extender_mode [*3] |-> panel_data_oe == 3'h0)
      else $error("pins driven in extender mode");
   a_oe_driven: assert property ((!video_extender_mode) [*3] |-> panel_data_oe == 3'h7)
      else $error("pins not driven outside extender mode");
   a_ext_quiet: assert property ((!video_extender_mode) [*3] |-> extender_pixel == 3'h0)
      else $error("extender pixel active outside extender mode");
   a_one_sclk: assert property ($onehot0(sclks))
      else $error("more than one shift clock high");
   a_latch_clean: assert property (row_latch_pulse |-> !any_sclk)
      else $error("shift clock high during latch");
   a_latch_width: assert property ($rose(row_latch_pulse) |-> ##8 !row_latch_pulse)
      else $error("latch longer than one pixel tick");
   a_frame_start: assert property ($rose(frame_start_pulse) |-> !any_sclk && !row_latch_pulse)
      else $error("frame pulse not at line start");
   a_data_on_fall: assert property ($changed(panel_data_out) |-> !any_sclk)
      else $error("data changed while shift clock high");
   a_rise_stable: assert property ($rose(any_sclk) |-> $stable(panel_data_out))
      else $error("data moved at sampling edge");
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   cover property ($rose(column_shift_clock_low_half));
   cover property ($rose(column_shift_clock_high_half));
   cover property ($rose(row_latch_pulse));
   cover property ($rose(video_extender_mode));
endmodule
bind fpmux_pixel_out fpmux_props u_props (.sys_clk, .reset_n, .reg_read, .reg_rdata, .panel_data_out,
   .panel_data_oe, .column_shift_clock, .column_shift_clock_low_half, .column_shift_clock_high_half,
   .row_latch_pulse, .frame_start_pulse, .extender_pixel, .video_extender_mode);
`default_nettype wire

// File: test/fpmux_panel_model.sv
// Pixel word source and free-running pixel clock facing the mux
`timescale 1ns/100ps
`default_nettype none
module fpmux_panel_model (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic src_ready,
   output logic [15:0] src_data,
   output logic [15:0] used_word,
   output logic pixel_clk_in
);
   // Odd step so bit 0 toggles on every word
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         src_data <= 16'hA5C3;
         used_word <= 16'h0000;
      end else if (src_ready) begin
         used_word <= src_data;
         src_data <= src_data + 16'h02D7;
      end
   end
   // Offset keeps its edges away from sys_clk edges
   initial begin
      pixel_clk_in = 1'b0;
      #33;
      forever #80 pixel_clk_in = ~pixel_clk_in;
   end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the pixel output mux
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic pixel_clk_in, src_ready, column_shift_clock, column_shift_clock_low_half;
   logic column_shift_clock_high_half, row_latch_pulse, frame_start_pulse, video_extender_mode;
   logic [15:0] src_data, used_word;
   logic [2:0] panel_data_out, panel_data_oe, panel_data_in, extender_pixel;
   logic [2:0] ext_drive = 3'h0;
   int errors = 0;
   int compares = 0;
   int m, k;
   always #10 sys_clk = ~sys_clk;
   // Pin level from whoever drives it
   assign panel_data_in = (panel_data_oe & panel_data_out) | (~panel_data_oe & ext_drive);
   fpmux_pixel_out dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .pixel_clk_in, .src_data, .src_ready, .panel_data_out, .panel_data_oe, .panel_data_in,
      .column_shift_clock, .column_shift_clock_low_half, .column_shift_clock_high_half,
      .row_latch_pulse, .frame_start_pulse, .extender_pixel, .video_extender_mode);
   fpmux_panel_model partner (.sys_clk, .reset_n, .src_ready, .src_data, .used_word, .pixel_clk_in);
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check3(input logic [2:0] got, input logic [2:0] exp);
      check({29'h0, got}, {29'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 check(reg_rdata, e);
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: pick = column_shift_clock;
         1: pick = column_shift_clock_low_half;
         2: pick = column_shift_clock_high_half;
         3: pick = row_latch_pulse;
         default: pick = frame_start_pulse;
      endcase
   endfunction
   // Bounded wait for a rising strobe; a hang counts as a mismatch
   task automatic wait_rise(input int s);
      int n;
      logic was;
      was = 1'b1;
      for (n = 0; n < 600; n++) begin
         @(posedge sys_clk);
         #1;
         if (!was && pick(s) === 1'b1)
            return;
         was = pick(s);
      end
      check(32'h0, 32'h1);
      tally_and_finish;
   endtask
   function automatic logic [2:0] expect_data(input int md, input logic [15:0] w);
      case (md)
         3: expect_data = w[fpmux_pkg::FPMUX_TFT_GREEN_LSB +: 3];
         5: expect_data = {w[5], w[6], w[7]};
         9: expect_data = 3'h0;
         default: expect_data = w[2:0];
      endcase
   endfunction
   // Second-order STN uses the low half clock, first-order the high half
   function automatic int sel(input int md);
      sel = (md == 5) ? 1 : ((md == 4) ? 2 : 0);
   endfunction
   initial begin
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(fpmux_pkg::FPMUX_CTRL_OFFSET, 32'h0);
      rd(fpmux_pkg::FPMUX_AUX_OFFSET, 32'h0);
      rd(fpmux_pkg::FPMUX_LINE_OFFSET, 32'h50);
      rd(fpmux_pkg::FPMUX_FRAME_OFFSET, 32'hF0);
      rd(8'h14, 32'h0);
      check3(panel_data_oe, 3'h7);
      // Short lines and frames keep each mode brief
      wr(fpmux_pkg::FPMUX_LINE_OFFSET, 32'h2);
      wr(fpmux_pkg::FPMUX_FRAME_OFFSET, 32'h2);
      for (m = 0; m < 11; m++) begin
         wr(fpmux_pkg::FPMUX_CTRL_OFFSET, {27'h0, 1'b1, m[3:0]});
         for (k = 0; k < 5; k++) begin
            wait_rise(sel(m));
            check3({column_shift_clock, column_shift_clock_low_half, column_shift_clock_high_half}, 3'h4 >> sel(m));
            check3(panel_data_out, expect_data(m, used_word));
         end
         wait_rise(3);
         wait_rise(4);
         wr(fpmux_pkg::FPMUX_CTRL_OFFSET, {28'h0, m[3:0]});
      end
      wr(fpmux_pkg::FPMUX_AUX_OFFSET, 32'h80);
      rd(fpmux_pkg::FPMUX_AUX_OFFSET, 32'h80);
      // External source drives the released lines
      ext_drive <= 3'h5;
      repeat (8) @(posedge sys_clk);
      #1 check3(panel_data_oe, 3'h0);
      check3({2'h0, video_extender_mode}, 3'h1);
      check3(extender_pixel, 3'h5);
      rd(fpmux_pkg::FPMUX_STATUS_OFFSET, 32'h0005_0000);
      @(posedge sys_clk);
      ext_drive <= 3'h2;
      repeat (8) @(posedge sys_clk);
      #1 check3(extender_pixel, 3'h2);
      wr(fpmux_pkg::FPMUX_AUX_OFFSET, 32'h0);
      repeat (8) @(posedge sys_clk);
      #1 check3(panel_data_oe, 3'h7);
      check3(extender_pixel, 3'h0);
      check3({2'h0, video_extender_mode}, 3'h0);
      // Undefined mode code must keep every shift clock low
      wr(fpmux_pkg::FPMUX_CTRL_OFFSET, 32'h1B);
      for (k = 0; k < 40; k++) begin
         @(posedge sys_clk);
         #1 check3({column_shift_clock, column_shift_clock_low_half, column_shift_clock_high_half}, 3'h0);
      end
      // Reset while running brings back the defaults
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(fpmux_pkg::FPMUX_LINE_OFFSET, 32'h50);
      rd(fpmux_pkg::FPMUX_CTRL_OFFSET, 32'h0);
      check3(panel_data_oe, 3'h7);
      check3({column_shift_clock, column_shift_clock_low_half, column_shift_clock_high_half}, 3'h0);
      tally_and_finish;
   end
endmodule
`default_nettype wire
